// ==== common/can_bit_timing_pkg.sv ====
// Shared constants, types and register layout for the bit timing block
package can_bit_timing_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_PRESCALE_JUMP = 8'h2a;
    localparam logic [7:0] ADDR_SEG_A         = 8'h29;
    localparam logic [7:0] ADDR_SEG_B         = 8'h28;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_PRESCALE_JUMP = 8'h00;
    localparam logic [7:0] RST_SEG_A         = 8'h00;
    localparam logic [7:0] RST_SEG_B         = 8'h00;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int JUMP_MSB     = 7;
    localparam int JUMP_LSB     = 6;
    localparam int PRESC_MSB    = 5;
    localparam int PRESC_LSB    = 0;
    localparam int PS2SEL_BIT   = 7;
    localparam int TRIPLE_BIT   = 6;
    localparam int PS1_MSB      = 5;
    localparam int PS1_LSB      = 3;
    localparam int PROP_MSB     = 2;
    localparam int PROP_LSB     = 0;
    localparam int PS2_MSB      = 2;
    localparam int PS2_LSB      = 0;
    // Bits 5..3 of the second segment register are unimplemented
    localparam logic [7:0] SEG_B_MASK = 8'hc7;

    // ------------------------------------------------------------
    // Timing counts in time quanta
    // ------------------------------------------------------------
    localparam logic [3:0] SYNC_SEG_TQ = 4'h1;
    localparam logic [3:0] IPT_TQ      = 4'h2;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        SEG_SYNC = 4'b0001,
        SEG_PROP = 4'b0010,
        SEG_PS1  = 4'b0100,
        SEG_PS2  = 4'b1000
    } seg_state_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_t;

    typedef struct packed {
        logic tq_tick;
        logic sample_pulse;
        logic bit_start;
        logic sync_pulse;
    } timing_evt_t;

endpackage

// ==== logic/can_bit_timing_sync.sv ====
// Bit timing, sampling and synchronisation logic of a CAN controller
`timescale 1ns/100ps

// What this block does
// - Phase segment 1 spans 1 to 8 quanta, phase segment 2 spans 1 to 8 (2 to 8 when automatic).
// - Bit value is read at the last moment of phase segment 1.
// - Triple mode takes majority of samples at -1, -0.5 and 0 quanta.
// - Processing time is 2 quanta from sample point; automatic phase 2 base never shorter.
// - Jump width field bits 7..6 give its value plus one quanta.
// - Prescale field bits 5..0 give quantum of 2*(value+1) clocks.
// - Hard sync only on falling edge while idle; restarts at sync segment.
// - No resync in the same bit after a hard sync.
// - Phase error counted in quanta from sync segment, signed by position.
// - Phase error within jump width acts like a hard sync.
// - Large positive error lengthens phase 1 by exactly the jump width.
// - Large negative error shortens phase 2 by exactly the jump width.
// - Only recessive-to-dominant edges drive timing.
// - At most one synchronisation of any kind per bit time.
// - Edge counts only if last sampled bit differs from level after edge.
// - While transmitting, positive phase errors are not resynchronised.
// - Timing registers take writes only in configuration mode.
// - Phase 2 from its field when selected, else max of phase 1 and 2.
// - Prop and phase 1 fields set their segment lengths in quanta.
// - Sync segment opens every bit and lasts one quantum.
// - Bit is sync, prop, phase 1, phase 2 in order, summed.
// - Prop field bits 2..0, phase 1 bits 5..3, each value plus one.
module can_bit_timing_sync #(
    parameter int RX_SYNC_STAGES = 3
) (
    // Clock and reset
    input  wire logic                           sys_clk,
    input  wire logic                           resetn,
    // Register port
    input  wire can_bit_timing_pkg::reg_req_t   reg_req,
    output logic [7:0]                          rd_data,
    // Controller state
    input  wire logic                           config_mode,
    input  wire logic                           bus_idle,
    input  wire logic                           transmitting,
    // Bus line
    input  wire logic                           bus_receive_pin,
    // Timing results
    output can_bit_timing_pkg::timing_evt_t     timing_evt,
    output logic                                sampled_bit
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (RX_SYNC_STAGES < 3) begin : g_bad_stages
        $error("RX_SYNC_STAGES must be at least 3");
    end

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    logic [7:0] cfg_pj_r;
    logic [7:0] cfg_pj_nxt;
    logic [7:0] cfg_a_r;
    logic [7:0] cfg_a_nxt;
    logic [7:0] cfg_b_r;
    logic [7:0] cfg_b_nxt;
    logic [7:0] rd_data_nxt;

    always_comb begin
        cfg_pj_nxt  = cfg_pj_r;
        cfg_a_nxt   = cfg_a_r;
        cfg_b_nxt   = cfg_b_r;
        rd_data_nxt = 8'h00;
        if (reg_req.wr && config_mode) begin
            case (reg_req.addr)
                can_bit_timing_pkg::ADDR_PRESCALE_JUMP: cfg_pj_nxt = reg_req.wdata;
                can_bit_timing_pkg::ADDR_SEG_A:         cfg_a_nxt  = reg_req.wdata;
                can_bit_timing_pkg::ADDR_SEG_B:         cfg_b_nxt  = reg_req.wdata & can_bit_timing_pkg::SEG_B_MASK;
                default:                                cfg_pj_nxt = cfg_pj_r;
            endcase
        end
        if (reg_req.rd) begin
            case (reg_req.addr)
                can_bit_timing_pkg::ADDR_PRESCALE_JUMP: rd_data_nxt = cfg_pj_r;
                can_bit_timing_pkg::ADDR_SEG_A:         rd_data_nxt = cfg_a_r;
                can_bit_timing_pkg::ADDR_SEG_B:         rd_data_nxt = cfg_b_r;
                default:                                rd_data_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cfg_pj_r <= can_bit_timing_pkg::RST_PRESCALE_JUMP;
            cfg_a_r  <= can_bit_timing_pkg::RST_SEG_A;
            cfg_b_r  <= can_bit_timing_pkg::RST_SEG_B;
            rd_data  <= 8'h00;
        end else begin
            cfg_pj_r <= cfg_pj_nxt;
            cfg_a_r  <= cfg_a_nxt;
            cfg_b_r  <= cfg_b_nxt;
            rd_data  <= rd_data_nxt;
        end
    end

    // ------------------------------------------------------------
    // Field decode
    // ------------------------------------------------------------
    logic [5:0] tq_prescale;
    logic [3:0] sjw_len;
    logic [3:0] prop_len;
    logic [3:0] ps1_len;
    logic [3:0] ps2_field_len;
    logic [3:0] ps2_base;
    logic       triple_sample_sel;
    logic       ps2_length_sel;

    assign tq_prescale       = cfg_pj_r[can_bit_timing_pkg::PRESC_MSB:can_bit_timing_pkg::PRESC_LSB];
    assign triple_sample_sel = cfg_a_r[can_bit_timing_pkg::TRIPLE_BIT];
    assign ps2_length_sel    = cfg_a_r[can_bit_timing_pkg::PS2SEL_BIT];
    // jump width is field plus one
    assign sjw_len = {2'b00, cfg_pj_r[can_bit_timing_pkg::JUMP_MSB:can_bit_timing_pkg::JUMP_LSB]} + 4'h1;
    // segment fields are value plus one
    assign prop_len = {1'b0, cfg_a_r[can_bit_timing_pkg::PROP_MSB:can_bit_timing_pkg::PROP_LSB]} + 4'h1;
    // phase 1 length from its field
    assign ps1_len       = {1'b0, cfg_a_r[can_bit_timing_pkg::PS1_MSB:can_bit_timing_pkg::PS1_LSB]} + 4'h1;
    assign ps2_field_len = {1'b0, cfg_b_r[can_bit_timing_pkg::PS2_MSB:can_bit_timing_pkg::PS2_LSB]} + 4'h1;

    // automatic phase 2 never below processing time
    always_comb begin
        if (ps2_length_sel) begin
            ps2_base = ps2_field_len;
        end else if (ps1_len > can_bit_timing_pkg::IPT_TQ) begin
            ps2_base = ps1_len;
        end else begin
            ps2_base = can_bit_timing_pkg::IPT_TQ;
        end
    end

    // ------------------------------------------------------------
    // Receive pin synchroniser
    // ------------------------------------------------------------
    logic [RX_SYNC_STAGES-1:0] rx_sync_r;
    logic                      rx_lvl_r;
    logic                      rx_lvl_nxt;
    logic                      rx_agree;

    assign rx_agree = rx_sync_r[RX_SYNC_STAGES-1] == rx_sync_r[RX_SYNC_STAGES-2];

    always_comb begin
        rx_lvl_nxt = rx_lvl_r;
        if (rx_agree) begin
            rx_lvl_nxt = rx_sync_r[RX_SYNC_STAGES-1];
        end
    end

    // Bus idles recessive, so the chain resets high
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rx_sync_r <= '1;
            rx_lvl_r  <= 1'b1;
        end else begin
            rx_sync_r <= {rx_sync_r[RX_SYNC_STAGES-2:0], bus_receive_pin};
            rx_lvl_r  <= rx_lvl_nxt;
        end
    end

    // ------------------------------------------------------------
    // Bit timing state
    // ------------------------------------------------------------
    can_bit_timing_pkg::seg_state_t seg_r;
    can_bit_timing_pkg::seg_state_t seg_nxt;
    logic [6:0] psc_r;
    logic [6:0] psc_nxt;
    logic [3:0] cnt_r;
    logic [3:0] cnt_nxt;
    logic [3:0] ext_r;
    logic [3:0] ext_nxt;
    logic [3:0] shrt_r;
    logic [3:0] shrt_nxt;
    logic       synced_r;
    logic       synced_nxt;
    logic [1:0] hist_r;
    logic [1:0] hist_nxt;
    logic       bit_nxt;
    logic       tq_evt;
    logic       half_evt;
    logic       edge_q;
    logic       maj;
    logic [3:0] ps1_eff;
    logic [3:0] ps2_eff;
    logic [4:0] pos_err;
    logic [3:0] neg_err;
    logic       restart;
    logic       smp_p;
    logic       start_p;
    logic       sync_p;

    // prescale counter feeds quantum tick
    // Compare is >= so a smaller prescale written mid-quantum never runs the counter round
    assign tq_evt   = psc_r >= {tq_prescale, 1'b1};
    assign half_evt = psc_r == {1'b0, tq_prescale};

    // last sampled bit must be recessive
    assign edge_q = rx_agree && !rx_sync_r[RX_SYNC_STAGES-1] && rx_lvl_r && sampled_bit;

    assign maj = (hist_r[0] & hist_r[1]) | (hist_r[0] & rx_lvl_r) | (hist_r[1] & rx_lvl_r);

    // phase 1 lengthened by jump width
    assign ps1_eff = ps1_len + ext_r;
    // phase 2 shortened by jump width
    // clamp guards against a misconfigured jump width
    assign ps2_eff = (ps2_base > shrt_r) ? ps2_base - shrt_r : 4'h1;

    always_comb begin
        pos_err = {1'b0, cnt_r} + 5'h01;
        if (seg_r == can_bit_timing_pkg::SEG_PS1) begin
            pos_err = {1'b0, prop_len} + {1'b0, cnt_r} + 5'h01;
        end
        neg_err = ps2_eff - cnt_r;
    end

    always_comb begin
        seg_nxt    = seg_r;
        cnt_nxt    = cnt_r;
        psc_nxt    = tq_evt ? 7'h00 : psc_r + 7'h01;
        ext_nxt    = ext_r;
        shrt_nxt   = shrt_r;
        synced_nxt = synced_r;
        hist_nxt   = hist_r;
        bit_nxt    = sampled_bit;
        restart    = 1'b0;
        smp_p      = 1'b0;
        start_p    = 1'b0;
        sync_p     = 1'b0;
        if (tq_evt || half_evt) begin
            hist_nxt = {hist_r[0], rx_lvl_r};
        end
        if (tq_evt) begin
            case (seg_r)
                can_bit_timing_pkg::SEG_SYNC: begin
                    if (cnt_r == can_bit_timing_pkg::SYNC_SEG_TQ - 4'h1) begin
                        seg_nxt = can_bit_timing_pkg::SEG_PROP;
                        cnt_nxt = 4'h0;
                    end else begin
                        cnt_nxt = cnt_r + 4'h1;
                    end
                end
                can_bit_timing_pkg::SEG_PROP: begin
                    if (cnt_r == prop_len - 4'h1) begin
                        seg_nxt = can_bit_timing_pkg::SEG_PS1;
                        cnt_nxt = 4'h0;
                    end else begin
                        cnt_nxt = cnt_r + 4'h1;
                    end
                end
                can_bit_timing_pkg::SEG_PS1: begin
                    // sample at end of phase 1
                    if (cnt_r == ps1_eff - 4'h1) begin
                        seg_nxt = can_bit_timing_pkg::SEG_PS2;
                        cnt_nxt = 4'h0;
                        smp_p   = 1'b1;
                        bit_nxt = triple_sample_sel ? maj : rx_lvl_r;
                    end else begin
                        cnt_nxt = cnt_r + 4'h1;
                    end
                end
                can_bit_timing_pkg::SEG_PS2: begin
                    if (cnt_r == ps2_eff - 4'h1) begin
                        seg_nxt    = can_bit_timing_pkg::SEG_SYNC;
                        cnt_nxt    = 4'h0;
                        start_p    = 1'b1;
                        synced_nxt = 1'b0;
                        ext_nxt    = 4'h0;
                        shrt_nxt   = 4'h0;
                    end else begin
                        cnt_nxt = cnt_r + 4'h1;
                    end
                end
                default: begin
                    seg_nxt = can_bit_timing_pkg::SEG_SYNC;
                    cnt_nxt = 4'h0;
                end
            endcase
        end
        if (edge_q && !synced_r) begin
            if (bus_idle) begin
                restart = 1'b1;
            end else begin
                case (seg_r)
                    can_bit_timing_pkg::SEG_PROP, can_bit_timing_pkg::SEG_PS1: begin
                        if (!transmitting) begin
                            synced_nxt = 1'b1;
                            // small error acts as hard sync
                            if (pos_err <= {1'b0, sjw_len}) begin
                                restart = 1'b1;
                            end else begin
                                ext_nxt = sjw_len;
                            end
                        end
                    end
                    can_bit_timing_pkg::SEG_PS2: begin
                        synced_nxt = 1'b1;
                        if (neg_err <= sjw_len) begin
                            restart = 1'b1;
                        end else begin
                            shrt_nxt = sjw_len;
                        end
                    end
                    default: begin
                        // Edge inside sync segment: zero error
                        synced_nxt = 1'b1;
                    end
                endcase
            end
        end
        if (restart) begin
            seg_nxt    = can_bit_timing_pkg::SEG_SYNC;
            cnt_nxt    = 4'h0;
            psc_nxt    = 7'h00;
            ext_nxt    = 4'h0;
            shrt_nxt   = 4'h0;
            synced_nxt = 1'b1;
            sync_p     = 1'b1;
            start_p    = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            seg_r       <= can_bit_timing_pkg::SEG_SYNC;
            psc_r       <= 7'h00;
            cnt_r       <= 4'h0;
            ext_r       <= 4'h0;
            shrt_r      <= 4'h0;
            synced_r    <= 1'b0;
            hist_r      <= 2'b11;
            sampled_bit <= 1'b1;
            timing_evt  <= '0;
        end else begin
            seg_r       <= seg_nxt;
            psc_r       <= psc_nxt;
            cnt_r       <= cnt_nxt;
            ext_r       <= ext_nxt;
            shrt_r      <= shrt_nxt;
            synced_r    <= synced_nxt;
            hist_r      <= hist_nxt;
            sampled_bit <= bit_nxt;
            timing_evt  <= '{tq_tick: tq_evt, sample_pulse: smp_p, bit_start: start_p | sync_p, sync_pulse: sync_p};
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_tq_period: assert property (@(posedge sys_clk) disable iff (!resetn)
        (psc_r == 7'h00 && !restart) |-> ##1 (psc_r == 7'h01 || tq_prescale == 6'h00))
        else $error("Prescale counter did not advance");

    chk_sync_one_tq: assert property (@(posedge sys_clk) disable iff (!resetn)
        (seg_r == can_bit_timing_pkg::SEG_SYNC && tq_evt && !restart) |=> seg_r == can_bit_timing_pkg::SEG_PROP)
        else $error("Sync segment longer than one quantum");

    chk_sample_at_ps1: assert property (@(posedge sys_clk) disable iff (!resetn)
        smp_p |-> (seg_r == can_bit_timing_pkg::SEG_PS1 && tq_evt && cnt_r == ps1_eff - 4'h1))
        else $error("Sample not at end of phase 1");

    chk_triple_vote: assert property (@(posedge sys_clk) disable iff (!resetn)
        (smp_p && triple_sample_sel) |=> sampled_bit == $past(maj) && timing_evt.sample_pulse)
        else $error("Triple sample majority wrong");

    chk_single_read: assert property (@(posedge sys_clk) disable iff (!resetn)
        (smp_p && !triple_sample_sel) |=> sampled_bit == $past(rx_lvl_r))
        else $error("Single sample value wrong");

    chk_hard_sync: assert property (@(posedge sys_clk) disable iff (!resetn)
        (edge_q && bus_idle && !synced_r) |=> (seg_r == can_bit_timing_pkg::SEG_SYNC && cnt_r == 4'h0
            && psc_r == 7'h00 && timing_evt.sync_pulse))
        else $error("Hard sync did not restart bit");

    chk_one_sync: assert property (@(posedge sys_clk) disable iff (!resetn)
        (synced_r && !start_p) |-> !sync_p && ext_nxt == ext_r && shrt_nxt == shrt_r)
        else $error("Second synchronisation in one bit");

    chk_cfg_locked: assert property (@(posedge sys_clk) disable iff (!resetn)
        (reg_req.wr && !config_mode) |=> ($stable(cfg_pj_r) && $stable(cfg_a_r) && $stable(cfg_b_r)))
        else $error("Timing register changed outside config mode");

    chk_tx_no_pos: assert property (@(posedge sys_clk) disable iff (!resetn)
        (edge_q && transmitting && !bus_idle && (seg_r == can_bit_timing_pkg::SEG_PROP
            || seg_r == can_bit_timing_pkg::SEG_PS1)) |-> (!sync_p && ext_nxt == ext_r))
        else $error("Transmitter resynchronised on positive error");

    chk_jump_exact: assert property (@(posedge sys_clk) disable iff (!resetn)
        $rose(ext_r != 4'h0) |-> ext_r == sjw_len ##1 ext_r == sjw_len || timing_evt.bit_start)
        else $error("Phase 1 extension not equal to jump width");

    chk_ps2_floor: assert property (@(posedge sys_clk) disable iff (!resetn)
        (!ps2_length_sel && shrt_r == 4'h0 && seg_r == can_bit_timing_pkg::SEG_PS2 && tq_evt
            && cnt_r == ps2_eff - 4'h1)
        |-> (cnt_r >= can_bit_timing_pkg::IPT_TQ - 4'h1 && cnt_r >= ps1_len - 4'h1))
        else $error("Automatic phase 2 below processing time");

endmodule

// ==== sim/can_bus_node_model.sv ====
// Model of another node driving the shared CAN bus line
`timescale 1ns/100ps

module can_bus_node_model (
    // Clock
    input  wire logic sys_clk,
    // Shared line, 1 recessive, 0 dominant
    output logic      bus_line
);
    // ----------------------------------------
    // Line driver
    // ----------------------------------------
    // Released line returns to recessive, as the termination pulls it there
    initial bus_line = 1'b1;

    task automatic send(input logic level, input int clks);
        @(posedge sys_clk);
        bus_line <= level;
        repeat (clks) @(posedge sys_clk);
        bus_line <= 1'b1;
    endtask
endmodule

// ==== sim/can_bit_timing_sync_tb.sv ====
// Self-checking bench for the bit timing block
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin fail_count++; $display("[ERR] %s exp %0h got %0h", nm, ex, got); end end

module can_bit_timing_sync_tb;
    logic                            sys_clk;
    logic                            resetn;
    can_bit_timing_pkg::reg_req_t    reg_req;
    logic [7:0]                      rd_data;
    logic                            config_mode;
    logic                            bus_idle;
    logic                            transmitting;
    logic                            bus_line;
    can_bit_timing_pkg::timing_evt_t timing_evt;
    logic                            sampled_bit;
    logic [3:0]                      ev;
    logic [7:0]                      d;
    int                              fail_count;
    int                              checks;
    int                              n;
    int                              zeros;
    int                              nsync;
    // Software keeps legal segments: prop+ps1 >= ps2 > jump width, ps2 >= 2
    logic [7:0] cfg [3][3] = '{'{8'h00, 8'h00, 8'h00}, '{8'h02, 8'h51, 8'h00}, '{8'hc1, 8'h83, 8'h04}};
    // Quantum clocks, bit quanta, quanta up to the sample point
    int         exp_t [3][3] = '{'{2, 5, 3}, '{6, 9, 6}, '{4, 11, 6}};

    assign ev = timing_evt;

    can_bit_timing_sync DUT (
        .sys_clk         (sys_clk),
        .resetn          (resetn),
        .reg_req         (reg_req),
        .rd_data         (rd_data),
        .config_mode     (config_mode),
        .bus_idle        (bus_idle),
        .transmitting    (transmitting),
        .bus_receive_pin (bus_line),
        .timing_evt      (timing_evt),
        .sampled_bit     (sampled_bit)
    );

    can_bus_node_model u_node (
        .sys_clk  (sys_clk),
        .bus_line (bus_line)
    );

    // ----------------------------------------
    // Clock, watchdog, verdict
    // ----------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    initial begin
        #200us;
        fail_count++;
        results();
    end

    task automatic results();
        if (fail_count == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // ----------------------------------------
    // Register port and event timing tasks
    // ----------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge sys_clk) reg_req <= '{a, v, 1'b1, 1'b0};
        @(posedge sys_clk) reg_req <= '0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge sys_clk) reg_req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge sys_clk) reg_req <= '0;
        #1 v = rd_data;
    endtask

    // Cycles from one event pulse to the next of another; bounded wait
    task automatic gap(input int a, input int b, output int cnt);
        int k;
        k = 0;
        cnt = 0;
        do begin @(posedge sys_clk); #1; k++; end while (ev[a] !== 1'b1 && k < 999);
        do begin @(posedge sys_clk); #1; cnt++; end while (ev[b] !== 1'b1 && cnt < 999);
    endtask

    // Short dominant pulse launched d clocks after a natural bit start; cycles to the next bit start
    task automatic late_edge(input int d, output int cnt);
        do begin @(posedge sys_clk); #1; end while (ev[1] !== 1'b1 || ev[0] !== 1'b0);
        fork
            begin repeat (d - 1) @(posedge sys_clk); u_node.send(1'b0, 8); end
            begin cnt = 0; do begin @(posedge sys_clk); #1; cnt++; end while (ev[1] !== 1'b1 && cnt < 999); end
        join
    endtask

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        resetn = 1'b0;
        reg_req = '0;
        config_mode = 1'b0;
        bus_idle = 1'b1;
        transmitting = 1'b0;
        fail_count = 0;
        checks = 0;
        repeat (3) @(posedge sys_clk);
        resetn <= 1'b1;
        #1 `CHK("sampled_bit", 1'b1, sampled_bit)
        for (int i = 0; i < 3; i++) begin
            rd(8'h2a - i, d);
            `CHK("reset value", 8'h00, d)
        end
        rd(8'h30, d);
        `CHK("unmapped", 8'h00, d)
        config_mode <= 1'b1;
        for (int c = 0; c < 3; c++) begin
            for (int i = 0; i < 3; i++) wr(8'h2a - i, cfg[c][i]);
            for (int i = 0; i < 3; i++) begin
                rd(8'h2a - i, d);
                `CHK("readback", cfg[c][i], d)
            end
            repeat (2) gap(3, 3, n);
            `CHK("quantum", exp_t[c][0], n)
            repeat (2) gap(1, 1, n);
            `CHK("bit time", exp_t[c][0] * exp_t[c][1], n)
            gap(1, 2, n);
            `CHK("sample point", exp_t[c][0] * exp_t[c][2], n)
        end
        wr(8'h28, 8'hff);
        rd(8'h28, d);
        `CHK("seg_b mask", can_bit_timing_pkg::SEG_B_MASK, d)
        wr(8'h28, 8'h04);
        config_mode <= 1'b0;
        wr(8'h2a, 8'h3f);
        rd(8'h2a, d);
        `CHK("locked write", 8'hc1, d)
        // One dominant bit while idle: a single hard sync, one low sample
        zeros = 0;
        nsync = 0;
        fork
            u_node.send(1'b0, 44);
            for (int k = 0; k < 120; k++) begin
                @(posedge sys_clk);
                #1 nsync += ev[0];
                if (ev[2] === 1'b1 && sampled_bit === 1'b0) zeros++;
            end
        join
        `CHK("sync count", 1, nsync)
        `CHK("low samples", 1, zeros)
        // Edges inside a frame: jump width 4, quantum 4 clocks, bit 11 quanta
        bus_idle <= 1'b0;
        late_edge(6, n);
        `CHK("small error restart", 10, n)
        late_edge(18, n);
        `CHK("phase 1 stretch", 60, n)
        late_edge(22, n);
        `CHK("phase 2 shrink", 28, n)
        transmitting <= 1'b1;
        late_edge(18, n);
        `CHK("transmit no stretch", 44, n)
        results();
    end
endmodule
